// [rtl/spi_config_consts.svh]
/*
  register map offsets, field positions, reset values and serial frame
  layout for the configuration register bank.
  assumes inclusion by bare name from the rtl folder.
*/
`ifndef SPI_CONFIG_CONSTS_SVH
`define SPI_CONFIG_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ADDR_PORT_SETUP      8'h00
`define ADDR_PART_ID         8'h01
`define ADDR_SPEED_VARIANT   8'h02
`define ADDR_CHAN_INDEX_HI   8'h04
`define ADDR_CHAN_INDEX_LO   8'h05
`define ADDR_PROG_FIRST      8'h08
`define ADDR_PROG_LAST       8'h2D
`define ADDR_TRANSFER        8'hFF
`define PROG_COUNT           38

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PORT_LSB_HI          6
`define PORT_SOFT_HI         5
`define PORT_SOFT_LO         2
`define PORT_LSB_LO          1
`define VARIANT_HI           5
`define VARIANT_LO           4
`define TRANSFER_BIT         0
`define INSTR_RW             15
`define INSTR_LEN_HI         14
`define INSTR_LEN_LO         13
`define INSTR_ADDR_HI        7
`define BYTE_MSB             7
`define BYTE_LAST            3'h7
`define INSTR_LAST           4'hF
`define LEN_STREAM           2'h3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PART_ID_DEFAULT      8'h5A  // arbitrary value
`define PORT_FIXED_ONES      8'h18
`define CHAN_INDEX_DEFAULT   8'h0F
`define PROG_DEFAULT         8'h00
`define PROG_CLOCK_INDEX     1
`define PROG_CLOCK_DEFAULT   8'h01
`define READ_UNMAPPED        8'h00

`endif

// [rtl/spi_config_pkg.sv]
/*
  types shared by the serial frame engine and the register bank.
  assumes nothing beyond the constants header.
*/
package spi_config_pkg;

  typedef enum logic [0:0] {PH_INSTR, PH_DATA} phase_e;

  typedef logic [7:0] byte_t;

  typedef struct packed {
    phase_e      phase;
    logic [3:0]  bit_cnt;
    logic [15:0] shift;
    logic        rw;
    logic [1:0]  len;
    logic [1:0]  byte_cnt;
    byte_t       addr;
    byte_t       out_byte;
    logic        sclk_prev;
    logic        sdio_out;
    logic        sdio_oe_n;
    logic        wr_stb;
    byte_t       wr_addr;
    byte_t       wr_data;
  } engine_s;

  typedef struct packed {
    logic                 lsb_first;
    logic [1:0]           variant;
    byte_t                chan_hi;
    byte_t                chan_lo;
    logic [37:0][7:0]     prog_master;
    logic [37:0][7:0]     prog_active;
  } bank_s;

endpackage : spi_config_pkg

// [rtl/serial_frame_engine.sv]
/*
  serial control port frame engine: 16-bit instruction, then one to
  three data bytes or a stream, msb or lsb first.
  assumes sclk, csb_n and sdio_in synchronous to clk and sclk well below
  half the clk rate.
*/
`timescale 1ns/10ps
`include "spi_config_consts.svh"

module serial_frame_engine
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 sclk,
  input  wire logic                 csb_n,
  input  wire logic                 sdio_in,
  input  wire logic                 lsb_first,
  input  wire spi_config_pkg::byte_t rd_data,
  output spi_config_pkg::byte_t      rd_addr,
  output logic                      wr_stb,
  output spi_config_pkg::byte_t      wr_addr,
  output spi_config_pkg::byte_t      wr_data,
  output logic                      sdio_out,
  output logic                      sdio_oe_n
);

  spi_config_pkg::engine_s s_reg;
  spi_config_pkg::engine_s s_next;

  assign rd_addr   = s_reg.addr;
  assign wr_stb    = s_reg.wr_stb;
  assign wr_addr   = s_reg.wr_addr;
  assign wr_data   = s_reg.wr_data;
  assign sdio_out  = s_reg.sdio_out;
  assign sdio_oe_n = s_reg.sdio_oe_n;

  // ----------------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic        rise;
    logic        fall;
    logic [15:0] sh;
    logic [15:0] word;
    spi_config_pkg::byte_t data;
    spi_config_pkg::byte_t ob;
    rise = 1'b0;
    fall = 1'b0;
    sh   = '0;
    word = '0;
    data = '0;
    ob   = '0;
    s_next = s_reg;
    s_next.wr_stb    = 1'b0;
    s_next.sclk_prev = sclk;
    rise = sclk & ~s_reg.sclk_prev;
    fall = ~sclk & s_reg.sclk_prev;
    sh   = {s_reg.shift[14:0], sdio_in};
    if (csb_n)
    begin
      // stall after the instruction or between data bytes keeps place; mid-instruction, mid-byte or stream end restarts
      s_next.sdio_oe_n = 1'b1;
      if (s_reg.bit_cnt != 4'h0 || s_reg.len == `LEN_STREAM)
      begin
        s_next.phase   = spi_config_pkg::PH_INSTR;
        s_next.bit_cnt = 4'h0;
      end
    end
    else if (rise)
    begin
      s_next.shift   = sh;
      s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
      if (s_reg.phase == spi_config_pkg::PH_INSTR)
      begin
        if (s_reg.bit_cnt == `INSTR_LAST)
        begin
          word = lsb_first ? {<<{sh}} : sh;
          s_next.rw       = word[`INSTR_RW];
          s_next.len      = word[`INSTR_LEN_HI:`INSTR_LEN_LO];
          s_next.addr     = word[`INSTR_ADDR_HI:0];
          s_next.byte_cnt = 2'h0;
          s_next.bit_cnt  = 4'h0;
          s_next.phase    = spi_config_pkg::PH_DATA;
        end
      end
      else if (s_reg.bit_cnt[2:0] == `BYTE_LAST)
      begin
        data = lsb_first ? {<<{sh[7:0]}} : sh[7:0];
        s_next.bit_cnt = 4'h0;
        if (!s_reg.rw)
        begin
          s_next.wr_stb  = 1'b1;
          s_next.wr_addr = s_reg.addr;
          s_next.wr_data = data;
        end
        s_next.addr = lsb_first ? s_reg.addr + 8'h01 : s_reg.addr - 8'h01;
        if (s_reg.len != `LEN_STREAM && s_reg.byte_cnt == s_reg.len)
        begin
          s_next.phase     = spi_config_pkg::PH_INSTR;
          s_next.sdio_oe_n = 1'b1;
        end
        else
          s_next.byte_cnt = s_reg.byte_cnt + 2'h1;
      end
    end
    else if (fall && s_reg.phase == spi_config_pkg::PH_DATA && s_reg.rw)
    begin
      // readback drives each bit from the falling edge before its rise
      ob = (s_reg.bit_cnt == 4'h0) ? rd_data : s_reg.out_byte;
      s_next.out_byte  = ob;
      s_next.sdio_oe_n = 1'b0;
      s_next.sdio_out  = lsb_first ? ob[s_reg.bit_cnt[2:0]]
                                   : ob[`BYTE_LAST - s_reg.bit_cnt[2:0]];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg           <= '0;
      s_reg.phase     <= spi_config_pkg::PH_INSTR;
      s_reg.sdio_oe_n <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

endmodule : serial_frame_engine

// [rtl/spi_config_register_bank.sv]
/*
  configuration register bank behind the three-wire serial control port:
  chip configuration, channel index, transfer command and shadowed
  program function registers.
  assumes a host that keeps the serial framing; clk well above sclk.
*/
// Operation
// - only the program region 0x08 to 0x2D written to shadow first
// - decode chip config, index/transfer and program function regions
// - every location eight bits, bit 7 most significant
// - any reset loads default values into configuration registers
// - port setup mirrors soft reset and lsb first; bits 4,3 read one
`timescale 1ns/10ps
`include "spi_config_consts.svh"

module spi_config_register_bank
(
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           sclk,
  input  wire logic           csb_n,
  input  wire logic           sdio_in,
  input  wire logic [1:0]     variant_code,
  output logic                sdio_out,
  output logic                sdio_oe_n,
  output logic                lsb_first,
  output logic [7:0]          chan_index_hi,
  output logic [7:0]          chan_index_lo,
  output logic [303:0]        prog_active
);

  localparam spi_config_pkg::byte_t PART_ID = `PART_ID_DEFAULT; // arbitrary

  spi_config_pkg::bank_s s_reg;
  spi_config_pkg::bank_s s_next;
  spi_config_pkg::byte_t rd_addr;
  spi_config_pkg::byte_t rd_data;
  spi_config_pkg::byte_t wr_addr;
  spi_config_pkg::byte_t wr_data;
  logic                  wr_stb;
  logic                  rd_prog;
  logic                  wr_prog;
  logic [5:0]            rd_index;
  logic [5:0]            wr_index;
  spi_config_pkg::byte_t port_image;
  spi_config_pkg::byte_t speed_image;

  assign lsb_first     = s_reg.lsb_first;
  assign chan_index_hi = s_reg.chan_hi;
  assign chan_index_lo = s_reg.chan_lo;
  assign prog_active   = s_reg.prog_active;

  // ----------------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------------
  serial_frame_engine u_engine
  (
    .clk       (clk),
    .rst       (rst),
    .sclk      (sclk),
    .csb_n     (csb_n),
    .sdio_in   (sdio_in),
    .lsb_first (s_reg.lsb_first),
    .rd_data   (rd_data),
    .rd_addr   (rd_addr),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .sdio_out  (sdio_out),
    .sdio_oe_n (sdio_oe_n)
  );

  // ----------------------------------------------------------------------
  // region decode
  // ----------------------------------------------------------------------
  // window offsets are only meaningful while the region flag is set
  always_comb
  begin
    spi_config_pkg::byte_t roff;
    spi_config_pkg::byte_t woff;
    roff     = rd_addr - `ADDR_PROG_FIRST;
    woff     = wr_addr - `ADDR_PROG_FIRST;
    rd_prog  = (rd_addr >= `ADDR_PROG_FIRST)
             && (rd_addr <= `ADDR_PROG_LAST);
    wr_prog  = (wr_addr >= `ADDR_PROG_FIRST)
             && (wr_addr <= `ADDR_PROG_LAST);
    rd_index = roff[5:0];
    wr_index = woff[5:0];
  end

  // ----------------------------------------------------------------------
  // fixed register images
  // ----------------------------------------------------------------------
  // soft reset bits self clear, so they always read back as zero
  always_comb
  begin
    port_image               = `PORT_FIXED_ONES;
    port_image[`PORT_LSB_HI] = s_reg.lsb_first;
    port_image[`PORT_LSB_LO] = s_reg.lsb_first;
  end

  always_comb
  begin
    speed_image                          = '0;
    speed_image[`VARIANT_HI:`VARIANT_LO] = s_reg.variant;
  end

  // ----------------------------------------------------------------------
  // default image
  // ----------------------------------------------------------------------
  function automatic spi_config_pkg::bank_s defaults
  (
    input logic [1:0] variant
  );
    spi_config_pkg::bank_s d;
    d = '0;
    d.lsb_first = 1'b0;
    d.variant   = variant;
    d.chan_hi   = `CHAN_INDEX_DEFAULT;
    d.chan_lo   = `CHAN_INDEX_DEFAULT;
    for (int i = 0; i < `PROG_COUNT; i++)
    begin
      d.prog_master[i] = `PROG_DEFAULT;
      d.prog_active[i] = `PROG_DEFAULT;
    end
    d.prog_master[`PROG_CLOCK_INDEX] = `PROG_CLOCK_DEFAULT;
    d.prog_active[`PROG_CLOCK_INDEX] = `PROG_CLOCK_DEFAULT;
    return d;
  endfunction : defaults

  // ----------------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------------
  always_comb
  begin
    rd_data = `READ_UNMAPPED;
    case (rd_addr)
      `ADDR_PORT_SETUP:
      begin
        rd_data = port_image;
      end
      `ADDR_PART_ID:
      begin
        rd_data = PART_ID;
      end
      `ADDR_SPEED_VARIANT:
      begin
        rd_data = speed_image;
      end
      `ADDR_CHAN_INDEX_HI:
      begin
        rd_data = s_reg.chan_hi;
      end
      `ADDR_CHAN_INDEX_LO:
      begin
        rd_data = s_reg.chan_lo;
      end
      `ADDR_TRANSFER:
      begin
        // transfer bit self clears
        rd_data = `READ_UNMAPPED;
      end
      default:
      begin
        // program region shows the shadow stage
        if (rd_prog)
          rd_data = s_reg.prog_master[rd_index];
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.variant = variant_code;
    if (wr_stb)
    begin
      case (wr_addr)
        `ADDR_PORT_SETUP:
        begin
          // either nibble sets a bit, whatever the shift order
          if (wr_data[`PORT_SOFT_HI] | wr_data[`PORT_SOFT_LO])
            s_next = defaults(variant_code);
          else
            s_next.lsb_first = wr_data[`PORT_LSB_HI]
                             | wr_data[`PORT_LSB_LO];
        end
        `ADDR_PART_ID,
        `ADDR_SPEED_VARIANT:
        begin
          // read-only locations: the write is dropped
        end
        `ADDR_CHAN_INDEX_HI:
        begin
          s_next.chan_hi = wr_data;
        end
        `ADDR_CHAN_INDEX_LO:
        begin
          s_next.chan_lo = wr_data;
        end
        `ADDR_TRANSFER:
        begin
          if (wr_data[`TRANSFER_BIT])
            s_next.prog_active = s_reg.prog_master;
        end
        default:
        begin
          // shadow stage only; active copy waits for the transfer bit
          if (wr_prog)
            s_next.prog_master[wr_index] = wr_data;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_reg <= defaults(2'b00);
    else
      s_reg <= s_next;
  end

endmodule : spi_config_register_bank

// [testbench/spi_config_register_bank_assertions.sv]
/*
  port checker for the configuration register bank.
  assumes it sees the bank's own clk and rst.
*/
`timescale 1ns/10ps

module spi_config_bank_checker
(
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         sclk,
  input wire logic         csb_n,
  input wire logic         sdio_out,
  input wire logic         lsb_first,
  input wire logic [7:0]   chan_index_hi,
  input wire logic [7:0]   chan_index_lo,
  input wire logic [303:0] prog_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ------
  // steps
  // ------
  sequence rise_taken;
    $past(sclk, 2) && !$past(sclk, 3) && !$past(csb_n, 2);
  endsequence

  sequence fall_seen;
    !$past(sclk) && $past(sclk, 2);
  endsequence

  chan_defaults_a:
    assert property ($fell(rst) |-> chan_index_hi == 8'h0F
      && chan_index_lo == 8'h0F && !lsb_first)
    else $error("index or bit order not at default after reset");
  prog_defaults_a:
    assert property ($fell(rst) |-> prog_active == 304'h100)
    else $error("program stage not at default after reset");
  shadow_hold_a:
    assert property (!$stable(prog_active) |-> rise_taken)
    else $error("program stage moved without a serial write");
  index_write_a:
    assert property (!$stable({chan_index_hi, chan_index_lo})
      |-> rise_taken)
    else $error("index moved without a serial write");
  order_write_a:
    assert property (!$stable(lsb_first) |-> rise_taken)
    else $error("bit order moved without a serial write");
  readback_edge_a:
    assert property (!$stable(sdio_out) |-> fall_seen)
    else $error("readback bit moved off a clock fall");
endmodule : spi_config_bank_checker

bind spi_config_register_bank spi_config_bank_checker u_checker
(
  .clk          (clk),
  .rst          (rst),
  .sclk         (sclk),
  .csb_n        (csb_n),
  .sdio_out     (sdio_out),
  .lsb_first    (lsb_first),
  .chan_index_hi(chan_index_hi),
  .chan_index_lo(chan_index_lo),
  .prog_active  (prog_active)
);

// [testbench/serial_host_model.sv]
/*
  serial control host: one instruction and one or two bytes a frame,
  msb or lsb first.
  assumes clk is the bank clock; changes lines on its falling edge.
*/
`timescale 1ns/10ps

module serial_host_model
(
  input  wire logic clk,
  input  wire logic sdio_out,
  output logic      sclk,
  output logic      csb_n,
  output logic      sdio_drv
);
  initial
  begin
    sclk = 1'b0;
    csb_n = 1'b1;
    sdio_drv = 1'b0;
  end

  // ------
  // frames
  // ------
  // released line shows the inverse of its last level
  task automatic shift_bit(input logic b, input logic drv,
                           output logic got);
    sdio_drv = drv ? b : ~sdio_drv;
    sclk = 1'b0;
    repeat (3) @(negedge clk);
    got = sdio_out;
    sclk = 1'b1;
    repeat (3) @(negedge clk);
  endtask : shift_bit

  function automatic logic [7:0] flip8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = v[7 - i];
    return r;
  endfunction : flip8

  // two selects a two-byte frame; first byte in wd[15:8] and rdat[15:8]
  task automatic frame(input logic rd, input logic lsb, input logic two,
                       input logic [7:0] a, input logic [15:0] wd,
                       output logic [15:0] rdat);
    logic [15:0] instr;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic        g;
    instr = {rd, 1'b0, two, 5'h00, a};
    if (lsb)
      instr = {flip8(instr[7:0]), flip8(instr[15:8])};
    rdat = 16'h0000;
    rx = 8'h00;
    csb_n = 1'b0;
    for (int i = 15; i >= 0; i--)
      shift_bit(instr[i], 1'b1, g);
    for (int k = 0; k < (two ? 2 : 1); k++)
    begin
      tx = (k == 0) ? wd[15:8] : wd[7:0];
      if (lsb)
        tx = flip8(tx);
      for (int i = 7; i >= 0; i--)
      begin
        shift_bit(tx[i], !rd, g);
        rx[i] = g;
      end
      if (lsb)
        rx = flip8(rx);
      if (k == 0)
        rdat[15:8] = rx;
      else
        rdat[7:0] = rx;
    end
    csb_n = 1'b1;
    repeat (3) @(negedge clk);
    sclk = 1'b0;
    repeat (3) @(negedge clk);
  endtask : frame
endmodule : serial_host_model

// [testbench/tb_top.sv]
/*
  self-checking bench: host frames against the register bank.
  assumes synchronous reset and write timing as handed over.
*/
`timescale 1ns/10ps
`include "spi_config_consts.svh"

module tb_top;
  logic         clk;
  logic         rst;
  logic [1:0]   variant_code;
  logic         sclk;
  logic         csb_n;
  logic         sdio_drv;
  logic         sdio_out;
  logic         sdio_oe_n;
  logic         lsb_first;
  logic [7:0]   chan_index_hi;
  logic [7:0]   chan_index_lo;
  logic [303:0] prog_active;
  logic         lsb_mode;
  wire logic    sdio_in;
  int           bad_count;
  int           n_tests;

  assign sdio_in = sdio_oe_n ? sdio_drv : sdio_out;

  spi_config_register_bank u_spi_config_register_bank
  (
    .clk          (clk),
    .rst          (rst),
    .sclk         (sclk),
    .csb_n        (csb_n),
    .sdio_in      (sdio_in),
    .variant_code (variant_code),
    .sdio_out     (sdio_out),
    .sdio_oe_n    (sdio_oe_n),
    .lsb_first    (lsb_first),
    .chan_index_hi(chan_index_hi),
    .chan_index_lo(chan_index_lo),
    .prog_active  (prog_active)
  );

  serial_host_model u_serial_host_model
  (
    .clk     (clk),
    .sdio_out(sdio_out),
    .sclk    (sclk),
    .csb_n   (csb_n),
    .sdio_drv(sdio_drv)
  );

  // ------
  // tasks
  // ------
  task automatic check(input logic [303:0] seen, input logic [303:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] x;
    u_serial_host_model.frame(1'b0, lsb_mode, 1'b0, a, {d, 8'h00}, x);
  endtask : wr

  task automatic wr2(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] x;
    u_serial_host_model.frame(1'b0, lsb_mode, 1'b1, a, d, x);
  endtask : wr2

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [15:0] d;
    u_serial_host_model.frame(1'b1, lsb_mode, 1'b0, a, 16'h0000, d);
    check(d[15:8], exp);
  endtask : rdchk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // ------
  // run
  // ------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial
  begin
    rst = 1'b1;
    variant_code = 2'b01;
    lsb_mode = 1'b0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(chan_index_hi, 8'h0F);
    check(prog_active, 304'h100);
    check(lsb_first, 1'b0);
    rdchk(`ADDR_PORT_SETUP, 8'h18);
    rdchk(`ADDR_PART_ID, `PART_ID_DEFAULT);
    check(sdio_oe_n, 1'b1);
    wr(`ADDR_SPEED_VARIANT, 8'hFF);
    rdchk(`ADDR_SPEED_VARIANT, 8'h10);
    wr(`ADDR_CHAN_INDEX_HI, 8'hA5);
    check(chan_index_hi, 8'hA5);
    wr(`ADDR_CHAN_INDEX_LO, 8'h3C);
    check(chan_index_lo, 8'h3C);
    wr2(`ADDR_CHAN_INDEX_LO, 16'hC35A);
    check(chan_index_lo, 8'hC3);
    check(chan_index_hi, 8'h5A);
    wr(`ADDR_PROG_FIRST, 8'h96);
    wr(`ADDR_PROG_LAST, 8'h81);
    check(prog_active, 304'h100);
    rdchk(`ADDR_PROG_FIRST, 8'h96);
    rdchk(8'h2E, `READ_UNMAPPED);
    wr(`ADDR_TRANSFER, 8'h01);
    check(prog_active, {8'h81, 280'h0, 8'h01, 8'h96});
    rdchk(`ADDR_TRANSFER, 8'h00);
    wr(`ADDR_PORT_SETUP, 8'h3C); // mirrored soft reset
    check(chan_index_hi, 8'h0F);
    check(chan_index_lo, 8'h0F);
    check(prog_active, 304'h100);
    rdchk(`ADDR_PORT_SETUP, 8'h18);
    wr(`ADDR_PORT_SETUP, 8'h5A);
    check(lsb_first, 1'b1);
    lsb_mode = 1'b1;
    rdchk(`ADDR_PORT_SETUP, 8'h5A);
    wr(`ADDR_CHAN_INDEX_LO, 8'h12);
    check(chan_index_lo, 8'h12);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    lsb_mode = 1'b0;
    @(negedge clk);
    check(lsb_first, 1'b0);
    check(chan_index_lo, 8'h0F);
    rdchk(`ADDR_PORT_SETUP, 8'h18);
    give_verdict();
  end
endmodule : tb_top
